// ==== ptm_pkg.sv ====
// Package with register map, field layout and reset values of the paired timer
package ptm_pkg;
    localparam int unsigned CNT_W    = 16;
    localparam int unsigned APB_AW   = 18;
    localparam int unsigned PS_W     = 8;
    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_LOW_COUNT  = 16'h0106;
    localparam logic [15:0] IDX_HIGH_HOLD  = 16'h0108;
    localparam logic [15:0] IDX_HIGH_COUNT = 16'h010A;
    localparam logic [15:0] IDX_PERIOD_LOW = 16'h010C;
    localparam logic [15:0] IDX_PERIOD_HI  = 16'h010E;
    localparam logic [15:0] IDX_CTRL_LOW   = 16'h0110;
    localparam logic [15:0] IDX_CTRL_HIGH  = 16'h0112;
    localparam logic [15:0] IDX_IRQ_STATUS = 16'h0114;
    localparam logic [15:0] IDX_IRQ_MASK   = 16'h0116;
    // Control field positions
    localparam int unsigned ON_BIT   = 15;
    localparam int unsigned IDLE_BIT = 13;
    localparam int unsigned GATE_BIT = 6;
    localparam int unsigned PS_HI    = 5;
    localparam int unsigned PS_LO    = 4;
    localparam int unsigned CASC_BIT = 3;
    localparam int unsigned CS_BIT   = 1;
    // Implemented control bits
    localparam logic [15:0] CTRL_LOW_MASK  = 16'hA07A;
    localparam logic [15:0] CTRL_HIGH_MASK = 16'hA072;
    // Reset values
    localparam logic [15:0] PERIOD_RST = 16'hFFFF;
    localparam logic [15:0] CTRL_RST   = 16'h0000;
    localparam logic [15:0] CNT_ZERO   = 16'h0000;
    localparam logic [15:0] CNT_ONE    = 16'h0001;
    localparam logic [15:0] CNT_MAX    = 16'hFFFF;
    // Prescaler terminal counts for divide by 1, 8, 64, 256
    localparam logic [7:0]  PS_TC1   = 8'h00;
    localparam logic [7:0]  PS_TC8   = 8'h07;
    localparam logic [7:0]  PS_TC64  = 8'h3F;
    localparam logic [7:0]  PS_TC256 = 8'hFF;
    // Interrupt status and mask layout
    localparam int unsigned ST_W    = 2;
    localparam int unsigned ST_LOW  = 0;
    localparam int unsigned ST_HIGH = 1;
endpackage

// ==== ptm_sync.sv ====
// Two-stage synchroniser for asynchronous pin inputs
module ptm_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clock,
    input  wire logic         resetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            meta_r <= '0;
            dout   <= '0;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule

// ==== ptm_prescale.sv ====
// Clock prescaler giving a one-cycle count enable every 1, 8, 64 or 256 source ticks
module ptm_prescale #(
    parameter bit SYNC_OUT = 1'b0
) (
    input  wire logic       clock,
    input  wire logic       resetn,
    input  wire logic       src_tick,
    input  wire logic       clear,
    input  wire logic [1:0] sel,
    output logic            tick_o
);
    logic [ptm_pkg::PS_W-1:0] count_r;
    wire  [ptm_pkg::PS_W-1:0] term;
    wire                      hit;
    wire  [ptm_pkg::PS_W-1:0] count_nxt;

    // Terminal count selection
    assign term = (sel == 2'h0) ? ptm_pkg::PS_TC1 :
                  (sel == 2'h1) ? ptm_pkg::PS_TC8 :
                  (sel == 2'h2) ? ptm_pkg::PS_TC64 : ptm_pkg::PS_TC256;
    assign hit       = src_tick && (count_r == term);
    assign count_nxt = clear ? '0 : (hit ? '0 : (src_tick ? count_r + 1'b1 : count_r));

    // Divider state
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    // Output either retimed to the internal clock or passed through
    generate
        if (SYNC_OUT) begin : g_sync
            logic tick_r;
            always_ff @(posedge clock or negedge resetn) begin
                if (!resetn) begin
                    tick_r <= 1'b0;
                end else begin
                    tick_r <= hit && !clear;
                end
            end
            // A tick retimed just before the timer was switched off must not land
            assign tick_o = tick_r && !clear;
        end else begin : g_direct
            assign tick_o = hit;
        end
    endgenerate
endmodule

// ==== ptm_timer.sv ====
// Paired 16-bit timer with 32-bit cascade, APB registers and interrupt
module ptm_timer (
    input  wire logic                        clock,
    input  wire logic                        resetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [ptm_pkg::APB_AW-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        ext_clk_low,
    input  wire logic                        ext_clk_high,
    input  wire logic                        gate_low,
    input  wire logic                        gate_high,
    input  wire logic                        cpu_idle,
    output logic      [ptm_pkg::CNT_W-1:0]   low_time_base,
    output logic      [ptm_pkg::CNT_W-1:0]   high_time_base,
    output logic                             adc_trigger,
    output logic                             irq
);
    ////////////////////////////////////////////////////////////////////////////
    logic [15:0]             timer_low_count_r;
    logic [15:0]             timer_high_count_r;
    logic [15:0]             timer_high_hold_r;
    logic [15:0]             period_low_r;
    logic [15:0]             period_high_r;
    logic [15:0]             timer_low_control_r;
    logic [15:0]             timer_high_control_r;
    logic [ptm_pkg::ST_W-1:0] irq_status_r;
    logic [ptm_pkg::ST_W-1:0] irq_mask_r;
    logic                    pready_r;
    logic                    pslverr_r;
    logic [31:0]             prdata_r;
    logic                    adc_r;
    logic                    irq_r;
    logic [1:0]              ext_prev_r;
    wire  [3:0]              pins_sync;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode
    wire setup    = psel && !penable;
    wire rd_setup = setup && !pwrite;
    wire wr_acc   = psel && penable && pwrite && pready_r;
    wire sel_low   = (paddr == {ptm_pkg::IDX_LOW_COUNT, 2'b00});
    wire sel_hold  = (paddr == {ptm_pkg::IDX_HIGH_HOLD, 2'b00});
    wire sel_high  = (paddr == {ptm_pkg::IDX_HIGH_COUNT, 2'b00});
    wire sel_prl   = (paddr == {ptm_pkg::IDX_PERIOD_LOW, 2'b00});
    wire sel_prh   = (paddr == {ptm_pkg::IDX_PERIOD_HI, 2'b00});
    wire sel_ctl   = (paddr == {ptm_pkg::IDX_CTRL_LOW, 2'b00});
    wire sel_cth   = (paddr == {ptm_pkg::IDX_CTRL_HIGH, 2'b00});
    wire sel_st    = (paddr == {ptm_pkg::IDX_IRQ_STATUS, 2'b00});
    wire sel_msk   = (paddr == {ptm_pkg::IDX_IRQ_MASK, 2'b00});
    wire sel_any   = sel_low | sel_hold | sel_high | sel_prl | sel_prh |
                     sel_ctl | sel_cth | sel_st | sel_msk;
    wire wr_low    = wr_acc && sel_low;
    wire wr_high   = wr_acc && sel_high;
    wire rd_low    = rd_setup && sel_low;
    wire rd_status = rd_setup && sel_st;

    // Read data selection; unimplemented bits are zero
    wire [15:0] rd_mux = sel_low  ? timer_low_count_r :
                         sel_hold ? timer_high_hold_r :
                         sel_high ? timer_high_count_r :
                         sel_prl  ? period_low_r :
                         sel_prh  ? period_high_r :
                         sel_ctl  ? timer_low_control_r :
                         sel_cth  ? timer_high_control_r :
                         sel_st   ? {14'h0000, irq_status_r} :
                         sel_msk  ? {14'h0000, irq_mask_r} : 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers for external clocks and gates
    ptm_sync #(.W(4)) u_sync (
        .clock  (clock),
        .resetn (resetn),
        .din    ({gate_high, gate_low, ext_clk_high, ext_clk_low}),
        .dout   (pins_sync)
    );

    // Previous synchronised external clock levels for edge detection
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ext_prev_r <= 2'b00;
        end else begin
            ext_prev_r <= pins_sync[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control fields
    wire        casc = timer_low_control_r[ptm_pkg::CASC_BIT];
    wire [15:0] ctl  = timer_low_control_r;
    wire [15:0] cth  = timer_high_control_r;
    wire [1:0]  ext_rise = pins_sync[1:0] & ~ext_prev_r;

    // Source ticks: instruction cycle or external edge, gated, on and idle stop
    wire run_l  = ctl[ptm_pkg::ON_BIT] && !(cpu_idle && ctl[ptm_pkg::IDLE_BIT]);
    wire run_h  = cth[ptm_pkg::ON_BIT] && !(cpu_idle && cth[ptm_pkg::IDLE_BIT]);
    wire gok_l  = !(ctl[ptm_pkg::GATE_BIT] && !ctl[ptm_pkg::CS_BIT]) || pins_sync[2];
    wire gok_h  = !(cth[ptm_pkg::GATE_BIT] && !cth[ptm_pkg::CS_BIT]) || pins_sync[3];
    wire src_l  = run_l && gok_l && (ctl[ptm_pkg::CS_BIT] ? ext_rise[0] : 1'b1);
    wire src_h  = run_h && gok_h && (cth[ptm_pkg::CS_BIT] ? ext_rise[1] : 1'b1);
    wire tick_l;
    wire tick_h;

    // Low prescaler is retimed, high is not
    ptm_prescale #(.SYNC_OUT(1'b1)) u_ps_low (
        .clock    (clock),
        .resetn   (resetn),
        .src_tick (src_l),
        .clear    (!ctl[ptm_pkg::ON_BIT]),
        .sel      (ctl[ptm_pkg::PS_HI:ptm_pkg::PS_LO]),
        .tick_o   (tick_l)
    );
    ptm_prescale #(.SYNC_OUT(1'b0)) u_ps_high (
        .clock    (clock),
        .resetn   (resetn),
        .src_tick (src_h && !casc),
        .clear    (!cth[ptm_pkg::ON_BIT]),
        .sel      (cth[ptm_pkg::PS_HI:ptm_pkg::PS_LO]),
        .tick_o   (tick_h)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Count next values
    wire match_l  = (timer_low_count_r == period_low_r);
    wire match_h  = (timer_high_count_r == period_high_r);
    wire match32  = match_l && match_h;
    wire wrap_l   = casc ? match32 : match_l;
    wire carry_l  = (timer_low_count_r == ptm_pkg::CNT_MAX);
    wire [15:0] low_inc  = timer_low_count_r + ptm_pkg::CNT_ONE;
    wire [15:0] high_inc = timer_high_count_r + ptm_pkg::CNT_ONE;
    wire [15:0] low_nxt  = wr_low ? pwdata[15:0] :
                           tick_l ? (wrap_l ? ptm_pkg::CNT_ZERO : low_inc) :
                           timer_low_count_r;
    // High half: own tick when split, carry of low half when cascaded
    wire [15:0] high_cas = (tick_l && match32) ? ptm_pkg::CNT_ZERO :
                           (tick_l && carry_l) ? high_inc : timer_high_count_r;
    wire [15:0] high_ind = tick_h ? (match_h ? ptm_pkg::CNT_ZERO : high_inc) :
                           timer_high_count_r;
    wire [15:0] high_nxt = wr_high ? pwdata[15:0] :
                           (casc && wr_low) ? timer_high_hold_r :
                           casc ? high_cas : high_ind;

    // Period match events
    wire ev_low  = !casc && tick_l && match_l && !wr_low;
    wire ev_high = casc ? (tick_l && match32 && !wr_low) :
                          (tick_h && match_h && !wr_high);
    wire [ptm_pkg::ST_W-1:0] ev_vec = {ev_high, ev_low};
    // Set wins over a read clear in the same cycle
    wire [ptm_pkg::ST_W-1:0] status_nxt = (rd_status ? '0 : irq_status_r) | ev_vec;
    wire [ptm_pkg::ST_W-1:0] mask_nxt   = (wr_acc && sel_msk) ?
                                          pwdata[ptm_pkg::ST_W-1:0] : irq_mask_r;

    ////////////////////////////////////////////////////////////////////////////
    // Counters and hold register
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            timer_low_count_r  <= ptm_pkg::CNT_ZERO;
            timer_high_count_r <= ptm_pkg::CNT_ZERO;
            timer_high_hold_r  <= ptm_pkg::CNT_ZERO;
        end else begin
            timer_low_count_r  <= low_nxt;
            timer_high_count_r <= high_nxt;
            if (rd_low) begin
                timer_high_hold_r <= timer_high_count_r;
            end else if (wr_acc && sel_hold) begin
                timer_high_hold_r <= pwdata[15:0];
            end
        end
    end

    // Period and control registers
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            period_low_r         <= ptm_pkg::PERIOD_RST;
            period_high_r        <= ptm_pkg::PERIOD_RST;
            timer_low_control_r  <= ptm_pkg::CTRL_RST;
            timer_high_control_r <= ptm_pkg::CTRL_RST;
        end else begin
            if (wr_acc && sel_prl) period_low_r <= pwdata[15:0];
            if (wr_acc && sel_prh) period_high_r <= pwdata[15:0];
            if (wr_acc && sel_ctl) begin
                timer_low_control_r <= pwdata[15:0] & ptm_pkg::CTRL_LOW_MASK;
            end
            if (wr_acc && sel_cth) begin
                timer_high_control_r <= pwdata[15:0] & ptm_pkg::CTRL_HIGH_MASK;
            end
        end
    end

    // Interrupt status, mask, outputs
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irq_status_r <= '0;
            irq_mask_r   <= '0;
            irq_r        <= 1'b0;
            adc_r        <= 1'b0;
        end else begin
            irq_status_r <= status_nxt;
            irq_mask_r   <= mask_nxt;
            irq_r        <= |(status_nxt & mask_nxt);
            adc_r        <= casc ? ev_high : ev_low;
        end
    end

    // APB answer: data and ready prepared in the setup cycle
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= setup;
            pslverr_r <= setup && !sel_any;
            if (rd_setup) prdata_r <= {16'h0000, rd_mux};
        end
    end

    // Time base outputs straight from the count registers
    assign low_time_base  = timer_low_count_r;
    assign high_time_base = timer_high_count_r;
    assign adc_trigger    = adc_r;
    assign irq            = irq_r;
    assign prdata         = prdata_r;
    assign pready         = pready_r;
    assign pslverr        = pslverr_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    wrap_low_a: assert property (ev_low |=> timer_low_count_r == ptm_pkg::CNT_ZERO
                                 && irq_status_r[ptm_pkg::ST_LOW])
        else $error("low timer did not wrap and flag");
    wrap_cascade_a: assert property (casc && tick_l && match32 && !wr_low && !wr_high
        |=> timer_low_count_r == ptm_pkg::CNT_ZERO && timer_high_count_r == ptm_pkg::CNT_ZERO
            && irq_status_r[ptm_pkg::ST_HIGH])
        else $error("cascaded count did not wrap");
    carry_high_a: assert property (casc && tick_l && carry_l && !match32
        && !wr_low && !wr_high |=> timer_high_count_r == $past(timer_high_count_r) + 16'h0001)
        else $error("carry into high half missing");
    hold_capture_a: assert property (rd_low && !(wr_acc && sel_hold)
        |=> timer_high_hold_r == $past(timer_high_count_r))
        else $error("hold register not captured");
    hold_copy_a: assert property (wr_low && casc && !wr_high
        |=> timer_high_count_r == $past(timer_high_hold_r))
        else $error("hold not copied into high count");
    idle_stop_a: assert property (cpu_idle && ctl[ptm_pkg::IDLE_BIT] && !wr_acc
        ##1 cpu_idle && !wr_acc |=> $stable(timer_low_count_r))
        else $error("low count moved during idle stop");
    off_hold_a: assert property (!ctl[ptm_pkg::ON_BIT] && !wr_acc
        |=> timer_low_count_r == $past(timer_low_count_r))
        else $error("low count moved while off");
    ctrl_zero_a: assert property (((timer_high_control_r & ~ptm_pkg::CTRL_HIGH_MASK) == 16'h0000)
        && ((timer_low_control_r & ~ptm_pkg::CTRL_LOW_MASK) == 16'h0000))
        else $error("unimplemented control bit set");
    cascade_split_a: assert property (casc |-> !tick_h && !ev_low)
        else $error("high timer ran on its own in cascade");
    irq_level_a: assert property (ev_high && irq_mask_r[ptm_pkg::ST_HIGH] && !(wr_acc && sel_msk)
        |=> irq ##1 (irq || !irq_status_r[ptm_pkg::ST_HIGH]))
        else $error("interrupt did not follow flag");
    apb_answer_a: assert property (setup |=> pready && (pslverr == !$past(sel_any)))
        else $error("apb answer missing");

    cas_wrap_c: cover property (casc && tick_l && match32);
    ind_wrap_c: cover property (ev_low ##[1:20] ev_high);
    hold_read_c: cover property (rd_low ##[1:4] (rd_setup && sel_hold));
    irq_clear_c: cover property (irq ##[1:10] !irq);
endmodule

// ==== ptm_ext_src.sv ====
// External clock source model that drives a counter clock pin
module ptm_ext_src (
    output logic ext_clk
);
    timeunit 1ns;
    timeprecision 1ns;

    // Pin rests low between bursts, so no stray edge reaches the counter
    initial ext_clk = 1'b0;

    // Sends a burst of rising edges with the given half period, then parks low
    task automatic burst(input int n, input int half);
        repeat (n) begin
            #half ext_clk = 1'b1;
            #half ext_clk = 1'b0;
        end
    endtask
endmodule

// ==== test_paired_timer_32bit.sv ====
// Self-checking bench for the paired timer, driven over APB
`define PTM_CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("BAD %0t got %h expected %h", $time, (a), (e)); end end

module test_paired_timer_32bit;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock, resetn, psel, penable, pwrite, gate_low, cpu_idle;
    logic        pready, pslverr, irq, ext_pin, err;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] rd, tb_low, tb_high;
    logic        adc;
    int          error_cnt = 0;
    int          checks    = 0;
    int          adc_cnt   = 0;
    int          adc_base;

    ptm_timer ptm_timer_inst (
        .clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_clk_low(ext_pin),
        .ext_clk_high(1'b0), .gate_low(gate_low), .gate_high(1'b0),
        .cpu_idle(cpu_idle), .low_time_base(tb_low), .high_time_base(tb_high),
        .adc_trigger(adc), .irq(irq)
    );

    // Counts trigger pulses seen at the rising edge
    always @(posedge clock) begin
        if (adc === 1'b1) adc_cnt++;
    end
    ptm_ext_src ptm_ext_src_inst (.ext_clk(ext_pin));

    ////////////////////////////////////////////////////////////////////////
    // Clock at 20 MHz
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // One APB transfer: setup, then access held until pready is seen
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [15:0] wd);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {16'h0000, wd};
        @(posedge clock);
        penable <= 1'b1;
        // Look at the answer mid-cycle, where it has settled; the watchdog ends a hang
        @(negedge clock);
        while (pready !== 1'b1) @(negedge clock);
        rd  = prdata[15:0];
        err = pslverr;
        @(posedge clock);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [15:0] d);
        apb(1'b1, idx, d);
    endtask

    // Read a register and compare with the expected word
    task automatic rdc(input logic [15:0] idx, input logic [15:0] exp);
        apb(1'b0, idx, 16'h0000);
        `PTM_CHK(rd, exp)
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog cuts a hung run short
    initial begin
        #(50 * 20000);
        error_cnt++;
        end_of_test();
    end

    // Test sequence
    initial begin
        {psel, penable, pwrite, cpu_idle} = 4'h0;
        {paddr, pwdata, resetn, gate_low} = '0;
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        rdc(ptm_pkg::IDX_PERIOD_LOW, 16'hFFFF);
        rdc(ptm_pkg::IDX_PERIOD_HI, 16'hFFFF);
        rdc(ptm_pkg::IDX_CTRL_LOW, 16'h0000);
        rdc(ptm_pkg::IDX_CTRL_HIGH, 16'h0000);
        apb(1'b0, 16'h0120, 16'h0000);
        `PTM_CHK(err, 1'b1)
        $display("test reset and map done");
        wr(ptm_pkg::IDX_CTRL_LOW, 16'hFFFF);
        rdc(ptm_pkg::IDX_CTRL_LOW, ptm_pkg::CTRL_LOW_MASK);
        wr(ptm_pkg::IDX_CTRL_HIGH, 16'hFFFF);
        rdc(ptm_pkg::IDX_CTRL_HIGH, ptm_pkg::CTRL_HIGH_MASK);
        wr(ptm_pkg::IDX_CTRL_HIGH, 16'h0000);
        wr(ptm_pkg::IDX_CTRL_LOW, 16'h0000);
        $display("test control fields done");
        // Independent low timer with interrupt masked
        wr(ptm_pkg::IDX_PERIOD_LOW, 16'h0004);
        wr(ptm_pkg::IDX_LOW_COUNT, 16'h0000);
        apb(1'b0, ptm_pkg::IDX_IRQ_STATUS, 16'h0000);
        wr(ptm_pkg::IDX_CTRL_LOW, 16'h8000);
        repeat (20) @(posedge clock);
        `PTM_CHK(irq, 1'b0)
        wr(ptm_pkg::IDX_CTRL_LOW, 16'h0000);
        rdc(ptm_pkg::IDX_IRQ_STATUS, 16'h0001);
        rdc(ptm_pkg::IDX_IRQ_STATUS, 16'h0000);
        $display("test low timer done");
        // Coherent 32-bit write and read in cascade
        wr(ptm_pkg::IDX_CTRL_LOW, 16'h0008);
        wr(ptm_pkg::IDX_HIGH_HOLD, 16'h1234);
        wr(ptm_pkg::IDX_LOW_COUNT, 16'h0005);
        rdc(ptm_pkg::IDX_HIGH_COUNT, 16'h1234);
        `PTM_CHK(tb_high, 16'h1234)
        wr(ptm_pkg::IDX_HIGH_HOLD, 16'hABCD);
        rdc(ptm_pkg::IDX_LOW_COUNT, 16'h0005);
        rdc(ptm_pkg::IDX_HIGH_HOLD, 16'h1234);
        $display("test coherent access done");
        // Cascade carry into the high half and 32-bit match
        wr(ptm_pkg::IDX_PERIOD_LOW, 16'h0001);
        wr(ptm_pkg::IDX_PERIOD_HI, 16'h0001);
        wr(ptm_pkg::IDX_HIGH_HOLD, 16'h0000);
        wr(ptm_pkg::IDX_LOW_COUNT, 16'hFFFE);
        wr(ptm_pkg::IDX_IRQ_MASK, 16'h0002);
        adc_base = adc_cnt;
        wr(ptm_pkg::IDX_CTRL_LOW, 16'h8008);
        repeat (12) @(posedge clock);
        `PTM_CHK(irq, 1'b1)
        `PTM_CHK(adc_cnt - adc_base, 1)
        wr(ptm_pkg::IDX_CTRL_LOW, 16'h0000);
        rdc(ptm_pkg::IDX_IRQ_STATUS, 16'h0002);
        repeat (3) @(posedge clock);
        `PTM_CHK(irq, 1'b0)
        $display("test cascade match done");
        // External clock counting, fast then slow edges
        wr(ptm_pkg::IDX_PERIOD_LOW, 16'hFFFF);
        wr(ptm_pkg::IDX_LOW_COUNT, 16'h0000);
        wr(ptm_pkg::IDX_CTRL_LOW, 16'h8002);
        ptm_ext_src_inst.burst(5, 100);
        ptm_ext_src_inst.burst(3, 400);
        repeat (10) @(posedge clock);
        wr(ptm_pkg::IDX_CTRL_LOW, 16'h0000);
        rdc(ptm_pkg::IDX_LOW_COUNT, 16'h0008);
        `PTM_CHK(tb_low, 16'h0008)
        $display("test external clock done");
        // Idle stop and closed gate both hold the count
        wr(ptm_pkg::IDX_LOW_COUNT, 16'h0010);
        cpu_idle <= 1'b1;
        wr(ptm_pkg::IDX_CTRL_LOW, 16'hA000);
        repeat (20) @(posedge clock);
        wr(ptm_pkg::IDX_CTRL_LOW, 16'h0000);
        cpu_idle <= 1'b0;
        rdc(ptm_pkg::IDX_LOW_COUNT, 16'h0010);
        wr(ptm_pkg::IDX_CTRL_LOW, 16'h8040);
        repeat (20) @(posedge clock);
        wr(ptm_pkg::IDX_CTRL_LOW, 16'h0000);
        rdc(ptm_pkg::IDX_LOW_COUNT, 16'h0010);
        $display("test idle and gate done");
        end_of_test();
    end
endmodule
